/* shared/sar_adc_pkg.sv */
// Constants, timing and state codes for the successive approximation converter control
// Overview of operation
// - Power-down low shuts down; chip select picks mode
// - Convert start and read need chip select low
// - Result pins driven only when read, select low
// - Convert start falling edge begins a conversion
// - Busy low throughout conversion, high when done
// - Result latched by the time busy rises
// - Approximation register cleared before bit decisions
// - Running conversion cannot be restarted
// - Decide bits one per step, MSB first
// - Whole approximation word loaded into output latches
// - Conversion paced by internally generated clock
// - Result is two's complement of input difference
package sar_adc_pkg;

	localparam int RESULT_WIDTH   = 14;
	localparam int CLK_PERIOD_NS  = 10;

	// Internal step period; clear step, 14 bit steps and a load cycle take about 1.8 us
	localparam int STEP_TIME_NS   = 120;
	localparam int STEP_CYCLES    = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CONV_STEPS     = RESULT_WIDTH + 2;

	// Host-side timing, kept for reference by the far end
	localparam int ACQ_TIME_NS    = 400;
	localparam int ACQ_CYCLES     = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAKE_TIME_NS   = 400;
	localparam int WAKE_CYCLES    = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CONVERT_START_SAFE_NS     = 900;
	localparam int CONVERT_START_SAFE_CYCLES = CONVERT_START_SAFE_NS / CLK_PERIOD_NS;

	localparam logic [RESULT_WIDTH-1:0] RESULT_RESET = 14'h0000;
	localparam logic [RESULT_WIDTH-1:0] APPROX_RESET = 14'h0000;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_CLEAR  = 4'b0010,
		ST_DECIDE = 4'b0100,
		ST_LOAD   = 4'b1000
	} state_type;

endpackage

/* src/conv_step_timer.sv */
// Internal step clock that paces each conversion step
module conv_step_timer #(
	parameter int STEP_CYCLES = sar_adc_pkg::STEP_CYCLES
) (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic run,
	input  wire logic restart,
	output logic      step
);

	localparam int CW = (STEP_CYCLES > 1) ? $clog2(STEP_CYCLES) : 1;
	localparam logic [CW-1:0] LAST = CW'(STEP_CYCLES - 1);

	logic [CW-1:0] count_ff;
	logic [CW-1:0] nxt_count;
	wire           at_last;

	assign at_last   = (count_ff == LAST);
	assign nxt_count = (restart || !run || at_last) ? '0 : count_ff + 1'b1;
	// Restart realigns the phase so every conversion has equal first step
	assign step      = run && !restart && at_last;

	always_ff @(posedge clk) begin
		if (srst) begin
			count_ff <= '0;
		end else begin
			count_ff <= nxt_count;
		end
	end

endmodule

/* src/sar_adc_parallel_control.sv */
// Control logic of a successive approximation converter with a parallel result port
module sar_adc_parallel_control #(
	parameter int WIDTH       = sar_adc_pkg::RESULT_WIDTH,
	parameter int STEP_CYCLES = sar_adc_pkg::STEP_CYCLES
) (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic             cs_n,
	input  wire logic             convert_start_n,
	input  wire logic             rd_n,
	input  wire logic             power_down_n,
	input  wire logic             comp_above,
	output logic                  busy_n,
	output logic [WIDTH-1:0]      result_bits,
	output logic                  result_oe_n,
	output logic [WIDTH-1:0]      dac_trial_code,
	output logic                  sample_acquire,
	output logic                  nap_mode,
	output logic                  sleep_mode
);

	localparam int IW = $clog2(WIDTH);
	localparam logic [IW-1:0] TOP_BIT = IW'(WIDTH - 1);
	localparam logic [IW-1:0] BIT_ZERO = '0;

	sar_adc_pkg::state_type state_ff;
	sar_adc_pkg::state_type nxt_state;

	logic [WIDTH-1:0] approx_register_ff;
	logic [WIDTH-1:0] nxt_approx_register;
	logic [WIDTH-1:0] result_bits_ff;
	logic [WIDTH-1:0] nxt_result_bits;
	logic [IW-1:0]    bit_idx_ff;
	logic [IW-1:0]    nxt_bit_idx;
	logic             convert_start_prev_ff;
	logic             power_down_prev_ff;
	logic             nap_mode_ff;
	logic             nxt_nap_mode;
	logic             sleep_mode_ff;
	logic             nxt_sleep_mode;

	wire              step;
	wire              start_fall;
	wire              start_take;
	wire              shutdown;
	wire              pd_fall;
	wire              in_idle;
	wire              in_clear;
	wire              in_decide;
	wire              in_load;
	wire              last_bit;
	wire [WIDTH-1:0]  bit_mask;
	wire [WIDTH-1:0]  twos_result;

	// Edge of convert start counts only with chip select low
	assign start_fall = convert_start_prev_ff && !convert_start_n && !cs_n;
	// New conversion only from idle and awake; later edges are ignored
	assign start_take = start_fall && in_idle && power_down_n;
	assign shutdown   = !power_down_n;
	assign pd_fall    = power_down_prev_ff && !power_down_n;

	assign in_idle   = (state_ff == sar_adc_pkg::ST_IDLE);
	assign in_clear  = (state_ff == sar_adc_pkg::ST_CLEAR);
	assign in_decide = (state_ff == sar_adc_pkg::ST_DECIDE);
	assign in_load   = (state_ff == sar_adc_pkg::ST_LOAD);
	assign last_bit  = (bit_idx_ff == BIT_ZERO);

	assign bit_mask    = WIDTH'(1) << bit_idx_ff;
	// Offset binary from the DAC becomes two's complement by MSB flip
	assign twos_result = {~approx_register_ff[WIDTH-1], approx_register_ff[WIDTH-2:0]};

	// Pins drive only while read and select are both low
	assign result_oe_n    = rd_n || cs_n;
	assign result_bits    = result_bits_ff;
	assign busy_n         = in_idle;
	assign dac_trial_code = in_decide ? (approx_register_ff | bit_mask) : approx_register_ff;
	assign sample_acquire = in_idle && power_down_n;
	assign nap_mode       = nap_mode_ff;
	assign sleep_mode     = sleep_mode_ff;

	conv_step_timer #(
		.STEP_CYCLES (STEP_CYCLES)
	) u_step_timer (
		.clk     (clk),
		.srst    (srst),
		.run     (!in_idle),
		.restart (start_take),
		.step    (step)
	);

	// Shutdown aborts a running conversion without touching the latches
	always_comb begin
		nxt_state   = state_ff;
		nxt_bit_idx = bit_idx_ff;
		unique case (state_ff)
			sar_adc_pkg::ST_IDLE: begin
				if (start_take) begin
					nxt_state = sar_adc_pkg::ST_CLEAR;
				end
			end
			sar_adc_pkg::ST_CLEAR: begin
				if (step) begin
					nxt_state   = sar_adc_pkg::ST_DECIDE;
					nxt_bit_idx = TOP_BIT;
				end
			end
			sar_adc_pkg::ST_DECIDE: begin
				if (step) begin
					if (last_bit) begin
						nxt_state = sar_adc_pkg::ST_LOAD;
					end else begin
						nxt_bit_idx = bit_idx_ff - 1'b1;
					end
				end
			end
			sar_adc_pkg::ST_LOAD: begin
				nxt_state = sar_adc_pkg::ST_IDLE;
			end
			default: begin
				nxt_state = sar_adc_pkg::ST_IDLE;
			end
		endcase
		if (shutdown) begin
			nxt_state = sar_adc_pkg::ST_IDLE;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_approx
			assign nxt_approx_register[gi] = start_take ? 1'b0 :
				(in_decide && step && (bit_idx_ff == IW'(gi))) ? comp_above :
				approx_register_ff[gi];
		end
	endgenerate

	// Latch updates only on completion, so repeated reads agree
	assign nxt_result_bits = in_load ? twos_result : result_bits_ff;

	// Mode is chosen by chip select at the falling edge of power-down
	assign nxt_nap_mode   = shutdown && (pd_fall ? !cs_n : nap_mode_ff);
	assign nxt_sleep_mode = shutdown && (pd_fall ? cs_n : sleep_mode_ff);

	always_ff @(posedge clk) begin
		if (srst) begin
			state_ff              <= sar_adc_pkg::ST_IDLE;
			bit_idx_ff            <= '0;
			approx_register_ff    <= sar_adc_pkg::APPROX_RESET;
			result_bits_ff        <= sar_adc_pkg::RESULT_RESET;
			convert_start_prev_ff <= 1'b1;
			power_down_prev_ff    <= 1'b1;
			nap_mode_ff           <= 1'b0;
			sleep_mode_ff         <= 1'b0;
		end else begin
			state_ff              <= nxt_state;
			bit_idx_ff            <= nxt_bit_idx;
			approx_register_ff    <= nxt_approx_register;
			result_bits_ff        <= nxt_result_bits;
			convert_start_prev_ff <= convert_start_n;
			power_down_prev_ff    <= power_down_n;
			nap_mode_ff           <= nxt_nap_mode;
			sleep_mode_ff         <= nxt_sleep_mode;
		end
	end

	// Longest busy time in clock cycles, with margin
	localparam int conv_bound = 260;

	property p_oe_gate;
		@(posedge clk) disable iff (srst)
		!result_oe_n |-> (!rd_n && !cs_n);
	endproperty
	a_oe_gate: assert property (p_oe_gate)
		else $error("result pins enabled without read and select");

	property p_start;
		@(posedge clk) disable iff (srst)
		(busy_n && $fell(convert_start_n) && !cs_n && power_down_n) |=> (!busy_n && approx_register_ff == '0);
	endproperty
	a_start: assert property (p_start)
		else $error("convert start edge did not begin a conversion");

	property p_cs_ignore;
		@(posedge clk) disable iff (srst)
		(busy_n && cs_n) |=> busy_n;
	endproperty
	a_cs_ignore: assert property (p_cs_ignore)
		else $error("conversion started with chip select high");

	property p_busy_span;
		@(posedge clk) disable iff (srst)
		($fell(busy_n) ##1 power_down_n[*1]) |-> ##[1:conv_bound] busy_n;
	endproperty
	a_busy_span: assert property (p_busy_span)
		else $error("busy stayed low too long");

	property p_busy_min;
		@(posedge clk) disable iff (srst)
		$fell(busy_n) |-> (!busy_n || !power_down_n)[*8];
	endproperty
	a_busy_min: assert property (p_busy_min)
		else $error("busy rose too early");

	property p_result_at_busy;
		@(posedge clk) disable iff (srst)
		($rose(busy_n) && power_down_n && $past(power_down_n))
			|-> (result_bits == {~approx_register_ff[WIDTH-1], approx_register_ff[WIDTH-2:0]});
	endproperty
	a_result_at_busy: assert property (p_result_at_busy)
		else $error("result not in latches when busy rose");

	property p_clear;
		@(posedge clk) disable iff (srst)
		in_clear |-> (approx_register_ff == '0);
	endproperty
	a_clear: assert property (p_clear)
		else $error("approximation register not cleared");

	property p_no_restart;
		@(posedge clk) disable iff (srst)
		(in_decide && start_fall) |=> !in_clear;
	endproperty
	a_no_restart: assert property (p_no_restart)
		else $error("running conversion was restarted");

	property p_msb_first;
		@(posedge clk) disable iff (srst)
		(in_clear && step && power_down_n) |=> (in_decide && bit_idx_ff == TOP_BIT);
	endproperty
	a_msb_first: assert property (p_msb_first)
		else $error("bit decisions did not start at the top bit");

	property p_hold;
		@(posedge clk) disable iff (srst)
		(busy_n && !in_load) |=> $stable(result_bits);
	endproperty
	a_hold: assert property (p_hold)
		else $error("result changed without a completed conversion");

	property p_nap;
		@(posedge clk) disable iff (srst)
		($fell(power_down_n) && !cs_n) |=> (nap_mode && !sleep_mode);
	endproperty
	a_nap: assert property (p_nap)
		else $error("nap mode not selected");

	property p_sleep;
		@(posedge clk) disable iff (srst)
		($fell(power_down_n) && cs_n) |=> (sleep_mode && !nap_mode);
	endproperty
	a_sleep: assert property (p_sleep)
		else $error("sleep mode not selected");

	property p_load_word;
		@(posedge clk) disable iff (srst)
		in_load |=> (result_bits[WIDTH-2:0] == $past(approx_register_ff[WIDTH-2:0]));
	endproperty
	a_load_word: assert property (p_load_word)
		else $error("approximation word not copied into the latches");

	property p_twos_msb;
		@(posedge clk) disable iff (srst)
		in_load |=> (result_bits[WIDTH-1] == !$past(approx_register_ff[WIDTH-1]));
	endproperty
	a_twos_msb: assert property (p_twos_msb)
		else $error("sign bit not inverted from offset binary");

	property p_step_hold;
		@(posedge clk) disable iff (srst)
		(in_decide && !step) |=> $stable(approx_register_ff);
	endproperty
	a_step_hold: assert property (p_step_hold)
		else $error("approximation register changed between steps");

	property p_bit_order;
		@(posedge clk) disable iff (srst)
		(in_decide && step && !last_bit && power_down_n)
			|=> (in_decide && (bit_idx_ff == $past(bit_idx_ff) - 1'b1));
	endproperty
	a_bit_order: assert property (p_bit_order)
		else $error("bit decisions not in descending order");

	property p_bit_decide;
		@(posedge clk) disable iff (srst)
		(in_decide && step) |=> (approx_register_ff[$past(bit_idx_ff)] == $past(comp_above));
	endproperty
	a_bit_decide: assert property (p_bit_decide)
		else $error("decided bit does not follow the comparator");

	property p_shutdown_abort;
		@(posedge clk) disable iff (srst)
		!power_down_n |=> busy_n;
	endproperty
	a_shutdown_abort: assert property (p_shutdown_abort)
		else $error("conversion kept running in shutdown");

	property p_wake;
		@(posedge clk) disable iff (srst)
		power_down_n |=> (!nap_mode && !sleep_mode);
	endproperty
	a_wake: assert property (p_wake)
		else $error("shutdown mode still shown while awake");

endmodule

/* verification/comparator_model.sv */
// Comparator stand-in holding the sampled input as an offset binary code
module comparator_model (
	input  wire logic [sar_adc_pkg::RESULT_WIDTH-1:0] dac_trial_code,
	input  wire logic [sar_adc_pkg::RESULT_WIDTH-1:0] vin,
	output logic                                      comp_above
);
	timeunit 1ns;
	timeprecision 1ps;
	// Input sits half an LSB above its code, so a tie never arises
	assign comp_above = ({vin, 1'b1} > {dac_trial_code, 1'b0});
endmodule

/* verification/sar_adc_parallel_control_bench.sv */
// Self-checking bench for the converter control block
module sar_adc_parallel_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk             = 1'b0;
	logic        srst            = 1'b1;
	logic        cs_n            = 1'b1;
	logic        convert_start_n = 1'b1;
	logic        rd_n            = 1'b1;
	logic        power_down_n    = 1'b1;
	logic [13:0] vin             = 14'h0000;
	logic        comp_above;
	logic        busy_n;
	logic [13:0] result_bits;
	logic        result_oe_n;
	logic [13:0] dac_trial_code;
	logic        sample_acquire;
	logic        nap_mode;
	logic        sleep_mode;
	int          mismatches      = 0;
	int          check_count     = 0;

	always #5 clk = ~clk;

	// Short step keeps each conversion at 31 busy cycles
	localparam int BENCH_STEP = 2;
	// Clear step, one step per result bit, then one load cycle
	localparam logic [13:0] BUSY_CYCLES = 14'((sar_adc_pkg::RESULT_WIDTH + 1) * BENCH_STEP + 1);
	sar_adc_parallel_control #(.STEP_CYCLES(BENCH_STEP)) i_dut (
		.clk             (clk),
		.srst            (srst),
		.cs_n            (cs_n),
		.convert_start_n (convert_start_n),
		.rd_n            (rd_n),
		.power_down_n    (power_down_n),
		.comp_above      (comp_above),
		.busy_n          (busy_n),
		.result_bits     (result_bits),
		.result_oe_n     (result_oe_n),
		.dac_trial_code  (dac_trial_code),
		.sample_acquire  (sample_acquire),
		.nap_mode        (nap_mode),
		.sleep_mode      (sleep_mode)
	);

	comparator_model i_comp (
		.dac_trial_code (dac_trial_code),
		.vin            (vin),
		.comp_above     (comp_above)
	);

	task chk_w(input logic [13:0] got, input logic [13:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task chk_b(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task convert(input logic [13:0] v, input bit again);
		int n;
		@(posedge clk);
		vin <= v;
		cs_n <= 1'b0;
		convert_start_n <= 1'b0;
		n = 0;
		while (busy_n !== 1'b0 && n < 4) begin
			@(posedge clk);
			#1 n++;
		end
		chk_b(busy_n, 1'b0);
		chk_w(dac_trial_code, 14'h0000);
		chk_b(sample_acquire, 1'b0);
		n = 0;
		while (busy_n === 1'b0 && n < 100) begin
			@(posedge clk);
			if (n == 1) convert_start_n <= 1'b1;
			if (again && n == 4) convert_start_n <= 1'b0;
			if (again && n == 6) convert_start_n <= 1'b1;
			#1 n++;
		end
		chk_w(14'(n), BUSY_CYCLES);
		chk_b(sample_acquire, 1'b1);
		chk_w(result_bits, {~v[13], v[12:0]});
		repeat (40) @(posedge clk);
		$display("done convert %h", v);
	endtask

	task read_back(input logic [13:0] e);
		@(posedge clk);
		rd_n <= 1'b0;
		#1 chk_b(result_oe_n, 1'b0);
		chk_w(result_bits, e);
		@(posedge clk);
		cs_n <= 1'b1;
		#1 chk_b(result_oe_n, 1'b1);
		chk_w(result_bits, e);
		@(posedge clk);
		rd_n <= 1'b1;
		cs_n <= 1'b0;
		#1 chk_b(result_oe_n, 1'b1);
		$display("done read");
	endtask

	task ignored();
		@(posedge clk);
		cs_n <= 1'b1;
		@(posedge clk);
		convert_start_n <= 1'b0;
		repeat (4) begin
			@(posedge clk);
			#1 chk_b(busy_n, 1'b1);
		end
		@(posedge clk);
		convert_start_n <= 1'b1;
		@(posedge clk);
		cs_n <= 1'b0;
		$display("done ignored start");
	endtask

	// Starts a conversion and aborts it, so latches must survive
	task shut(input logic cs);
		logic [13:0] keep;
		keep = result_bits;
		@(posedge clk);
		cs_n <= 1'b0;
		convert_start_n <= 1'b0;
		repeat (4) @(posedge clk);
		cs_n <= cs;
		convert_start_n <= 1'b1;
		@(posedge clk);
		power_down_n <= 1'b0;
		repeat (2) @(posedge clk);
		cs_n <= ~cs;
		#1 chk_b(nap_mode, ~cs);
		chk_b(sleep_mode, cs);
		chk_b(busy_n, 1'b1);
		chk_w(result_bits, keep);
		chk_b(sample_acquire, 1'b0);
		repeat (2) @(posedge clk);
		power_down_n <= 1'b1;
		cs_n <= 1'b0;
		#1 chk_b(sleep_mode, cs);
		repeat (2) @(posedge clk);
		#1 chk_b(nap_mode, 1'b0);
		chk_b(sleep_mode, 1'b0);
		repeat (40) @(posedge clk);
		$display("done shutdown %h", cs);
	endtask

	task wrap_up();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		#100000;
		mismatches++;
		wrap_up();
	end

	initial begin
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		#1 chk_w(result_bits, 14'h0000);
		chk_b(busy_n, 1'b1);
		convert(14'h0000, 1'b0);
		read_back(14'h2000);
		convert(14'h3fff, 1'b1);
		read_back(14'h1fff);
		convert(14'h2000, 1'b0);
		convert(14'h1555, 1'b0);
		read_back(14'h3555);
		ignored();
		shut(1'b0);
		shut(1'b1);
		convert(14'h2abc, 1'b0);
		read_back(14'h0abc);
		wrap_up();
	end
endmodule
